// file: verilog/dgc_global_ctl.sv
// dma global control: teardown source, emulation suspend and per-channel configuration
`timescale 1ns/1ps
`default_nettype none
module dgc_global_ctl #(
  parameter int NUM_TX = dgc_pkg::NUM_TX_DEFAULT,
  parameter int NUM_RX = dgc_pkg::NUM_RX_DEFAULT
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // ahb-lite register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // emulation suspend
  input wire logic emuSuspend,
  input wire logic engineBusy,
  output logic engineRun,
  output logic engineHalted,
  // teardown descriptor source
  output dgc_pkg::dgc_qref_type tdSource,
  // transmit channels
  input wire logic [NUM_TX-1:0] txTeardownDone,
  output dgc_pkg::dgc_tx_cfg_type [NUM_TX-1:0] txCfg,
  // receive channels
  input wire logic [NUM_RX-1:0] rxTeardownDone,
  input wire logic [NUM_RX-1:0] rxStarve,
  output dgc_pkg::dgc_rx_cfg_type [NUM_RX-1:0] rxCfg,
  output logic [NUM_RX-1:0] rxDropPkt,
  output logic [NUM_RX-1:0] rxRetryAlloc
);
  dgc_pkg::dgc_req_type req;
  logic [31:0] rdData;
  logic emuFree_r;
  logic emuSoft_r;

  // address of channel idx in a bank starting at base
  function automatic logic [dgc_pkg::ADDR_W-1:0] chanAddr(
    input logic [dgc_pkg::ADDR_W-1:0] base,
    input int idx
  );
    logic [dgc_pkg::ADDR_W-1:0] off;
    off = dgc_pkg::ADDR_W'(idx) << 2;
    return base + off;
  endfunction

  // write strobe for one register, shared by every bank
  function automatic logic wrHit(
    input dgc_pkg::dgc_req_type r,
    input logic [dgc_pkg::ADDR_W-1:0] a
  );
    return r.wr && (r.addr == a);
  endfunction

  // queue reference from a written word
  function automatic dgc_pkg::dgc_qref_type qrefOf(input logic [31:0] w);
    dgc_pkg::dgc_qref_type q;
    q.manager = w[dgc_pkg::MGR_MSB:dgc_pkg::MGR_LSB];
    q.queue = w[dgc_pkg::QUEUE_MSB:dgc_pkg::QUEUE_LSB];
    return q;
  endfunction

  // bus front end owns the wait state and the read data register
  dgc_ahb_slave u_bus (
    .clk(clk),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hwdata(hwdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .req(req),
    .regRdata(rdData)
  );

  // suspend response, fed by the two emulation control bits
  dgc_emu_halt u_emu (
    .clk(clk),
    .rst(rst),
    .suspend(emuSuspend),
    .freeRun(emuFree_r),
    .softStop(emuSoft_r),
    .busy(engineBusy),
    .runOk(engineRun),
    .halted(engineHalted)
  );

  // teardown descriptor source register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tdSource <= '0;
    end else if (wrHit(req, dgc_pkg::OFFS_TD_SOURCE)) begin
      tdSource <= qrefOf(req.wdata); // [RULE_01] [RULE_02] [RULE_17]
    end
  end

  // emulation control bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      emuFree_r <= 1'b0;
      emuSoft_r <= 1'b0;
    end else if (wrHit(req, dgc_pkg::OFFS_EMU_CTRL)) begin
      emuFree_r <= req.wdata[dgc_pkg::BIT_EMU_FREE]; // [RULE_03]
      emuSoft_r <= req.wdata[dgc_pkg::BIT_EMU_SOFT]; // [RULE_04] [RULE_05]
    end
  end

  // transmit channel registers; completion beats a same-cycle enable write
  for (genvar g = 0; g < NUM_TX; g++) begin : g_tx // [RULE_10]
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        txCfg[g] <= '0;
      end else begin
        if (wrHit(req, chanAddr(dgc_pkg::OFFS_TX_BASE, g))) begin
          txCfg[g].enable <= req.wdata[dgc_pkg::BIT_ENABLE]; // [RULE_06]
          txCfg[g].teardown <= req.wdata[dgc_pkg::BIT_TEARDOWN]; // [RULE_07]
          txCfg[g].ret <= qrefOf(req.wdata); // [RULE_08] [RULE_09]
        end
        // placed after the write so completion wins over a same-cycle enable
        if (txTeardownDone[g]) begin
          txCfg[g].enable <= 1'b0; // [RULE_06]
        end
      end
    end

    property p_tx_done_clears;
      @(posedge clk) disable iff (rst)
        txTeardownDone[g] |=> !txCfg[g].enable;
    endproperty
    a_tx_done_clears: assert property (p_tx_done_clears) else $error("tx enable kept"); // [RULE_06]

    property p_tx_td_holds;
      @(posedge clk) disable iff (rst)
        (txCfg[g].teardown && !wrHit(req, chanAddr(dgc_pkg::OFFS_TX_BASE, g)))
        |=> txCfg[g].teardown;
    endproperty
    a_tx_td_holds: assert property (p_tx_td_holds) else $error("tx teardown dropped"); // [RULE_07]

    property p_tx_ret_write;
      @(posedge clk) disable iff (rst)
        (wrHit(req, chanAddr(dgc_pkg::OFFS_TX_BASE, g)) && !txTeardownDone[g])
        |=> txCfg[g].ret == $past(qrefOf(req.wdata))
            && txCfg[g].enable == $past(req.wdata[dgc_pkg::BIT_ENABLE]);
    endproperty
    a_tx_ret_write: assert property (p_tx_ret_write) else $error("tx write lost"); // [RULE_09]

    // only software moves the teardown request bit
    property p_tx_td_write;
      @(posedge clk) disable iff (rst)
        wrHit(req, chanAddr(dgc_pkg::OFFS_TX_BASE, g))
        |=> txCfg[g].teardown == $past(req.wdata[dgc_pkg::BIT_TEARDOWN]);
    endproperty
    a_tx_td_write: assert property (p_tx_td_write) else $error("tx td write"); // [RULE_07]

    // the return queue moves on writes only
    property p_tx_ret_hold;
      @(posedge clk) disable iff (rst)
        !wrHit(req, chanAddr(dgc_pkg::OFFS_TX_BASE, g)) |=> $stable(txCfg[g].ret);
    endproperty
    a_tx_ret_hold: assert property (p_tx_ret_hold) else $error("tx queue moved"); // [RULE_08]
  end

  // receive channel registers; completion sets teardown over any write
  for (genvar g = 0; g < NUM_RX; g++) begin : g_rx // [RULE_11]
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        rxCfg[g] <= '0; // [RULE_13]
        rxCfg[g].kind <= dgc_pkg::RX_KIND_RESET;
      end else begin
        if (wrHit(req, chanAddr(dgc_pkg::OFFS_RX_BASE, g))) begin // [RULE_12]
          rxCfg[g].enable <= req.wdata[dgc_pkg::BIT_ENABLE];
          rxCfg[g].teardown <= req.wdata[dgc_pkg::BIT_TEARDOWN];
          rxCfg[g].errRetry <= req.wdata[dgc_pkg::BIT_ERR_RETRY]; // [RULE_13]
          rxCfg[g].skip <= req.wdata[dgc_pkg::SKIP_MSB:dgc_pkg::SKIP_LSB]; // [RULE_16]
          rxCfg[g].ret <= qrefOf(req.wdata);
        end
        // after the write: completion decides enable and teardown
        if (rxTeardownDone[g]) begin
          rxCfg[g].enable <= 1'b0; // [RULE_14]
          rxCfg[g].teardown <= 1'b1; // [RULE_14]
        end
      end
    end

    // starvation answer chosen by the error bit, only while the channel runs
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        rxDropPkt[g] <= 1'b0;
        rxRetryAlloc[g] <= 1'b0;
      end else begin
        rxDropPkt[g] <= rxStarve[g] && rxCfg[g].enable && !rxCfg[g].errRetry; // [RULE_15]
        rxRetryAlloc[g] <= rxStarve[g] && rxCfg[g].enable && rxCfg[g].errRetry; // [RULE_15]
      end
    end

    property p_rx_done;
      @(posedge clk) disable iff (rst)
        rxTeardownDone[g] |=> !rxCfg[g].enable && rxCfg[g].teardown;
    endproperty
    a_rx_done: assert property (p_rx_done) else $error("rx teardown not reported"); // [RULE_14]

    property p_rx_starve;
      @(posedge clk) disable iff (rst)
        (rxStarve[g] && rxCfg[g].enable)
        |=> (rxDropPkt[g] != rxRetryAlloc[g]) && (rxRetryAlloc[g] == $past(rxCfg[g].errRetry));
    endproperty
    a_rx_starve: assert property (p_rx_starve) else $error("wrong starvation answer"); // [RULE_15]

    property p_rx_kind_fixed;
      @(posedge clk) disable iff (rst)
        rxCfg[g].kind == dgc_pkg::RX_KIND_RESET;
    endproperty
    a_rx_kind_fixed: assert property (p_rx_kind_fixed) else $error("rx kind changed"); // [RULE_13]

    // write-only fields still land although they read back as zero
    property p_rx_write;
      @(posedge clk) disable iff (rst)
        wrHit(req, chanAddr(dgc_pkg::OFFS_RX_BASE, g))
        |=> rxCfg[g].skip == $past(req.wdata[dgc_pkg::SKIP_MSB:dgc_pkg::SKIP_LSB])
            && rxCfg[g].errRetry == $past(req.wdata[dgc_pkg::BIT_ERR_RETRY])
            && rxCfg[g].ret == $past(qrefOf(req.wdata));
    endproperty
    a_rx_write: assert property (p_rx_write) else $error("rx write lost"); // [RULE_16]

    // no answer without starvation on an enabled channel
    property p_rx_quiet;
      @(posedge clk) disable iff (rst)
        !(rxStarve[g] && rxCfg[g].enable) |=> !rxDropPkt[g] && !rxRetryAlloc[g];
    endproperty
    a_rx_quiet: assert property (p_rx_quiet) else $error("spurious answer"); // [RULE_15]

    // enable and teardown follow software unless completion lands too
    property p_rx_ctl_write;
      @(posedge clk) disable iff (rst)
        (wrHit(req, chanAddr(dgc_pkg::OFFS_RX_BASE, g)) && !rxTeardownDone[g])
        |=> rxCfg[g].enable == $past(req.wdata[dgc_pkg::BIT_ENABLE])
            && rxCfg[g].teardown == $past(req.wdata[dgc_pkg::BIT_TEARDOWN]);
    endproperty
    a_rx_ctl_write: assert property (p_rx_ctl_write) else $error("rx ctl lost"); // [RULE_14]
  end

  // read mux: write-only and reserved fields read zero, unmapped reads zero
  always_comb begin
    rdData = dgc_pkg::WORD_ZERO;
    // teardown source word
    if (req.addr == dgc_pkg::OFFS_TD_SOURCE) begin
      rdData[dgc_pkg::MGR_MSB:dgc_pkg::MGR_LSB] = tdSource.manager;
      rdData[dgc_pkg::QUEUE_MSB:dgc_pkg::QUEUE_LSB] = tdSource.queue;
    end
    // emulation control word
    if (req.addr == dgc_pkg::OFFS_EMU_CTRL) begin
      rdData[dgc_pkg::BIT_EMU_FREE] = emuFree_r;
      rdData[dgc_pkg::BIT_EMU_SOFT] = emuSoft_r;
    end
    // transmit words read back whole
    for (int i = 0; i < NUM_TX; i++) begin
      if (req.addr == chanAddr(dgc_pkg::OFFS_TX_BASE, i)) begin
        rdData[dgc_pkg::BIT_ENABLE] = txCfg[i].enable;
        rdData[dgc_pkg::BIT_TEARDOWN] = txCfg[i].teardown;
        rdData[dgc_pkg::MGR_MSB:dgc_pkg::MGR_LSB] = txCfg[i].ret.manager;
        rdData[dgc_pkg::QUEUE_MSB:dgc_pkg::QUEUE_LSB] = txCfg[i].ret.queue;
      end
    end
    // receive words hide their write-only fields
    for (int i = 0; i < NUM_RX; i++) begin
      if (req.addr == chanAddr(dgc_pkg::OFFS_RX_BASE, i)) begin
        rdData[dgc_pkg::BIT_ENABLE] = rxCfg[i].enable; // [RULE_13]
        rdData[dgc_pkg::BIT_TEARDOWN] = rxCfg[i].teardown;
        rdData[dgc_pkg::KIND_MSB:dgc_pkg::KIND_LSB] = rxCfg[i].kind; // [RULE_17]
      end
    end
  end

  property p_rx_read_mask;
    @(posedge clk) disable iff (rst)
      (req.addr >= dgc_pkg::OFFS_RX_BASE)
      |-> (rdData & ~dgc_pkg::RX_READ_MASK) == '0;
  endproperty
  a_rx_read_mask: assert property (p_rx_read_mask) else $error("rx hidden bits read back"); // [RULE_13]

  property p_td_source_write;
    @(posedge clk) disable iff (rst)
      wrHit(req, dgc_pkg::OFFS_TD_SOURCE)
      |=> tdSource == $past(qrefOf(req.wdata));
  endproperty
  a_td_source_write: assert property (p_td_source_write) else $error("teardown source lost"); // [RULE_01]

  property p_read_answer;
    @(posedge clk) disable iff (rst)
      (hsel && htrans[1] && hready && !hwrite)
      |=> !hreadyout ##1 hreadyout && hrdata == $past(rdData);
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer late or wrong"); // [RULE_17]

  // emulation control bits follow the written word
  property p_emu_write;
    @(posedge clk) disable iff (rst)
      wrHit(req, dgc_pkg::OFFS_EMU_CTRL)
      |=> emuFree_r == $past(req.wdata[dgc_pkg::BIT_EMU_FREE])
          && emuSoft_r == $past(req.wdata[dgc_pkg::BIT_EMU_SOFT]);
  endproperty
  a_emu_write: assert property (p_emu_write) else $error("emulation control lost"); // [RULE_03]

  // the source only moves on a write to its own address
  property p_td_source_hold;
    @(posedge clk) disable iff (rst)
      !wrHit(req, dgc_pkg::OFFS_TD_SOURCE) |=> $stable(tdSource);
  endproperty
  a_td_source_hold: assert property (p_td_source_hold) else $error("source moved"); // [RULE_02]

  // writes finish with no wait state
  property p_write_no_wait;
    @(posedge clk) disable iff (rst)
      (hsel && htrans[1] && hready && hwrite) |=> hreadyout;
  endproperty
  a_write_no_wait: assert property (p_write_no_wait) else $error("write stalled"); // [RULE_17]

  // unmapped or reserved accesses still answer okay
  property p_resp_okay;
    @(posedge clk) disable iff (rst) !hresp;
  endproperty
  a_resp_okay: assert property (p_resp_okay) else $error("error response"); // [RULE_17]

  // run and halted are never shown together
  property p_run_halt_excl;
    @(posedge clk) disable iff (rst) !(engineRun && engineHalted);
  endproperty
  a_run_halt_excl: assert property (p_run_halt_excl) else $error("run and halted"); // [RULE_05]
endmodule
`default_nettype wire

// file: verilog/dgc_pkg.sv
// package: register map, field layout and carrier types of the dma global control block
// Functional notes
// [RULE_01] teardown source register bits 13:12 choose one of four queue managers
// [RULE_02] teardown source register bits 11:0 choose the queue inside that manager
// [RULE_03] free-run bit one keeps the engine running through suspend, soft bit ignored
// [RULE_04] free-run zero, soft zero: suspend input has no effect on the engine
// [RULE_05] free-run zero, soft one: finish current transaction on suspend, then halt
// [RULE_06] tx bit 31 enables channel; hardware clears it when teardown completes
// [RULE_07] software writes one to tx bit 30 to tear down; bit stays set afterwards
// [RULE_08] tx bits 13:12 name the return queue manager for teardown descriptors
// [RULE_09] tx bits 11:0 name the tx completion queue inside that manager
// [RULE_10] four transmit channels, each with its own global configuration register
// [RULE_11] four receive channels, each with its own global configuration register
// [RULE_12] software writes rx global register last when setting its enable bit
// [RULE_13] rx layout: 31,30 rw; 29:25 zero; 24..0 write-only but kind read-only; reset zero
// [RULE_14] rx teardown completion clears enable and sets the teardown bit
// [RULE_15] starvation: error bit zero drops packet, one retries allocation later
// [RULE_16] rx bits 23:16 give bytes skipped in first buffer; software keeps it small
// [RULE_17] reserved bits read zero and ignore writes
package dgc_pkg;
  // word offsets in the block's 256-byte window
  localparam logic [7:0] OFFS_TD_SOURCE = 8'h00;
  localparam logic [7:0] OFFS_EMU_CTRL = 8'h04;
  localparam logic [7:0] OFFS_TX_BASE = 8'h10;
  localparam logic [7:0] OFFS_RX_BASE = 8'h20;
  localparam int ADDR_W = 8;
  localparam int NUM_TX_DEFAULT = 4;
  localparam int NUM_RX_DEFAULT = 4;
  // field positions
  localparam int BIT_ENABLE = 31;
  localparam int BIT_TEARDOWN = 30;
  localparam int BIT_ERR_RETRY = 24;
  localparam int SKIP_LSB = 16;
  localparam int SKIP_MSB = 23;
  localparam int KIND_LSB = 14;
  localparam int KIND_MSB = 15;
  localparam int MGR_LSB = 12;
  localparam int MGR_MSB = 13;
  localparam int QUEUE_LSB = 0;
  localparam int QUEUE_MSB = 11;
  localparam int BIT_EMU_FREE = 0;
  localparam int BIT_EMU_SOFT = 1;
  // reset values and the rx read-back mask
  localparam logic [1:0] RX_KIND_RESET = 2'h0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [31:0] RX_READ_MASK = 32'hC000_C000;
  // queue reference: manager and queue number
  typedef struct packed {
    logic [1:0] manager;
    logic [11:0] queue;
  } dgc_qref_type;
  typedef struct packed {
    logic enable;
    logic teardown;
    dgc_qref_type ret;
  } dgc_tx_cfg_type;
  typedef struct packed {
    logic enable;
    logic teardown;
    logic errRetry;
    logic [7:0] skip;
    logic [1:0] kind;
    dgc_qref_type ret;
  } dgc_rx_cfg_type;
  // register access from the bus front end
  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } dgc_req_type;
endpackage

// file: verilog/dgc_ahb_slave.sv
// ahb-lite slave front end: zero-wait writes, one-wait reads
`timescale 1ns/1ps
`default_nettype none
module dgc_ahb_slave (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // register side
  output dgc_pkg::dgc_req_type req,
  input wire logic [31:0] regRdata
);
  logic accept;
  logic wrPhase_r;
  logic rdWait_r;
  logic [dgc_pkg::ADDR_W-1:0] addr_r;

  // word transfers only, so hsize does not steer anything
  assign accept = hsel && htrans[1] && hready && (hsize == hsize);

  // address phase capture; reads get one wait so the mux sees committed writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_r <= '0;
      wrPhase_r <= 1'b0;
      rdWait_r <= 1'b0;
      hreadyout <= 1'b1;
    end else begin
      wrPhase_r <= accept && hwrite;
      rdWait_r <= accept && !hwrite;
      if (accept) begin
        addr_r <= haddr[dgc_pkg::ADDR_W-1:0];
      end
      hreadyout <= !(accept && !hwrite);
    end
  end

  // read data is latched in the wait cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= dgc_pkg::WORD_ZERO;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (rdWait_r) begin
        hrdata <= regRdata;
      end
    end
  end

  assign req.wr = wrPhase_r;
  assign req.addr = addr_r;
  assign req.wdata = hwdata;
endmodule
`default_nettype wire

// file: verilog/dgc_emu_halt.sv
// emulation suspend response: run, drain the current transaction, halt
`timescale 1ns/1ps
`default_nettype none
module dgc_emu_halt (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic suspend,
  input wire logic freeRun,
  input wire logic softStop,
  input wire logic busy,
  // status
  output logic runOk,
  output logic halted
);
  typedef enum logic [1:0] {RUN, DRAIN, HALTED} dgc_emu_state_type;
  dgc_emu_state_type state_r, state_nxt;
  logic stopReq;

  // free wins over soft; soft zero ignores suspend
  assign stopReq = suspend && !freeRun && softStop; // [RULE_03] [RULE_04]

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      // always drain first: the engine may launch a transaction at this very edge
      RUN: if (stopReq) state_nxt = DRAIN; // [RULE_05]
      DRAIN: begin
        if (!stopReq) state_nxt = RUN;
        else if (!busy) state_nxt = HALTED; // [RULE_05]
      end
      HALTED: if (!stopReq) state_nxt = RUN;
      default: state_nxt = RUN;
    endcase
  end

  // registered view of the next state keeps outputs glitch free
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= RUN;
      runOk <= 1'b1;
      halted <= 1'b0;
    end else begin
      state_r <= state_nxt;
      runOk <= (state_nxt == RUN);
      halted <= (state_nxt == HALTED);
    end
  end

  property p_free_runs;
    @(posedge clk) disable iff (rst) (freeRun || !softStop) |=> runOk && !halted;
  endproperty
  a_free_runs: assert property (p_free_runs) else $error("engine stopped without soft stop"); // [RULE_03]

  property p_soft_halts;
    @(posedge clk) disable iff (rst) (stopReq && !busy && !runOk) |=> halted && !runOk;
  endproperty
  a_soft_halts: assert property (p_soft_halts) else $error("idle engine did not halt"); // [RULE_05]

  property p_busy_no_halt;
    @(posedge clk) disable iff (rst) (!halted && busy) |=> !halted;
  endproperty
  a_busy_no_halt: assert property (p_busy_no_halt) else $error("halted mid transaction"); // [RULE_05]
endmodule
`default_nettype wire

// file: bench/dgc_engine_model.sv
// behavioural engine and queue manager side: transactions and teardown completion
`timescale 1ns/1ps
`default_nettype none
module dgc_engine_model #(
  parameter int NUM_TX = 4,
  parameter int NUM_RX = 4,
  parameter int TD_LAT = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configuration from the block
  input wire dgc_pkg::dgc_tx_cfg_type [NUM_TX-1:0] txCfg,
  input wire dgc_pkg::dgc_rx_cfg_type [NUM_RX-1:0] rxCfg,
  input wire logic engineRun,
  // traffic control from the bench
  input wire logic work,
  input wire logic [3:0] txnLen,
  // engine status
  output logic engineBusy,
  output logic [NUM_TX-1:0] txTeardownDone,
  output logic [NUM_RX-1:0] rxTeardownDone
);
  localparam int NCH = NUM_TX + NUM_RX;
  logic [NCH-1:0] tdReq;
  logic [NCH-1:0] tdSeen_r;
  logic [NCH-1:0] tdDone_r;
  logic [3:0] tdCnt_r [NCH];
  logic [3:0] busyCnt_r;
  // a channel asks for teardown while enabled with its teardown bit set
  always_comb begin
    for (int i = 0; i < NUM_TX; i++) tdReq[i] = txCfg[i].enable & txCfg[i].teardown;
    for (int i = 0; i < NUM_RX; i++) tdReq[NUM_TX+i] = rxCfg[i].enable & rxCfg[i].teardown;
  end
  // one done pulse per request; the seen flag stops a repeat while enable is still high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tdSeen_r <= '0;
      tdDone_r <= '0;
      for (int i = 0; i < NCH; i++) tdCnt_r[i] <= 4'h0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        tdDone_r[i] <= 1'b0;
        if (!tdReq[i]) begin
          tdSeen_r[i] <= 1'b0;
          tdCnt_r[i] <= 4'h0;
        end else if (!tdSeen_r[i] && tdCnt_r[i] == 4'(TD_LAT)) begin
          tdSeen_r[i] <= 1'b1;
          tdDone_r[i] <= 1'b1;
        end else if (!tdSeen_r[i]) begin
          tdCnt_r[i] <= tdCnt_r[i] + 4'h1;
        end
      end
    end
  end
  assign txTeardownDone = tdDone_r[NUM_TX-1:0];
  assign rxTeardownDone = tdDone_r[NCH-1:NUM_TX];
  // new transactions start only while the block lets the engine run
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busyCnt_r <= 4'h0;
    end else if (busyCnt_r != 4'h0) begin
      busyCnt_r <= busyCnt_r - 4'h1;
    end else if (work && engineRun) begin
      busyCnt_r <= txnLen;
    end
  end
  assign engineBusy = (busyCnt_r != 4'h0);
endmodule
`default_nettype wire

// file: bench/tb_dgc_global_ctl.sv
// self-checking bench for the dma global control block
`timescale 1ns/1ps
`default_nettype none
module tb_dgc_global_ctl;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic emuSuspend = 1'b0;
  logic work = 1'b0;
  logic [3:0] txnLen = 4'h2;
  logic engineBusy;
  logic engineRun;
  logic engineHalted;
  dgc_pkg::dgc_qref_type tdSource;
  logic [3:0] txTeardownDone;
  logic [3:0] rxTeardownDone;
  logic [3:0] rxDropPkt;
  logic [3:0] rxRetryAlloc;
  logic [3:0] rxStarve = 4'h0;
  dgc_pkg::dgc_tx_cfg_type [3:0] txCfg;
  dgc_pkg::dgc_rx_cfg_type [3:0] rxCfg;
  integer seed = 77;
  int failCount = 0;
  int checksDone = 0;
  // 25 MHz clock
  always #20 clk = ~clk;
  // the one slave's hreadyout is the bus's hready
  dgc_global_ctl #(.NUM_TX(4), .NUM_RX(4)) dut_u (.clk(clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .emuSuspend(emuSuspend), .engineBusy(engineBusy), .engineRun(engineRun),
    .engineHalted(engineHalted), .tdSource(tdSource), .txTeardownDone(txTeardownDone),
    .txCfg(txCfg), .rxTeardownDone(rxTeardownDone), .rxStarve(rxStarve), .rxCfg(rxCfg),
    .rxDropPkt(rxDropPkt), .rxRetryAlloc(rxRetryAlloc));
  dgc_engine_model #(.NUM_TX(4), .NUM_RX(4), .TD_LAT(3)) eng_u (.clk(clk), .rst(rst),
    .txCfg(txCfg), .rxCfg(rxCfg), .engineRun(engineRun), .work(work), .txnLen(txnLen),
    .engineBusy(engineBusy), .txTeardownDone(txTeardownDone),
    .rxTeardownDone(rxTeardownDone));
  // expected starvation outcome as {drop, retry}: case 2 is a disabled channel
  function automatic logic [31:0] starveExp(int e);
    return (e == 0) ? 32'h2 : (e == 1) ? 32'h1 : 32'h0;
  endfunction
  // expected {run, halted} once suspend has settled; only soft stop halts
  function automatic logic [31:0] emuExp(int m);
    return (m == 2) ? 32'h1 : 32'h2;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value at %0t: got %08h expected %08h", $time, got, exp);
    end
  endtask
  // one single transfer; outputs read at the edge hold pre-edge values
  task automatic bus(input logic isWr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= isWr;
    hsize <= 3'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wrReg(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask
  task automatic rdChk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0, rd);
    chk(rd, exp);
    chk(32'(hresp), 32'h0);
  endtask
  task automatic closeOut();
    $display("comparisons %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // watchdog: the whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    failCount++;
    closeOut();
  end
  initial begin
    logic [31:0] d;
    logic [31:0] a;
    logic [1:0] seen;
    int n;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    work <= 1'b1;
    @(posedge clk);
    // registers and the gaps between them read zero out of reset
    for (int i = 0; i <= 'h30; i += 4) rdChk(32'(i), 32'h0);
    wrReg(32'h08, 32'hFFFF_FFFF);
    rdChk(32'h08, 32'h0);
    // teardown source, all-ones corner first, then random
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
      wrReg(32'h00, d);
      rdChk(32'h00, d & 32'h0000_3FFF);
      chk(32'(tdSource), d & 32'h0000_3FFF);
    end
    // per-channel configuration with enable and teardown kept low
    for (int i = 0; i < 4; i++) begin
      d = $random(seed) & 32'h3FFF_FFFF;
      wrReg(32'h10 + 32'(4 * i), d);
      rdChk(32'h10 + 32'(4 * i), d & 32'h0000_3FFF);
      chk(32'(txCfg[i]), d & 32'h0000_3FFF);
      d = $random(seed) & 32'h3FFF_FFFF;
      wrReg(32'h20 + 32'(4 * i), d);
      rdChk(32'h20 + 32'(4 * i), 32'h0);
      chk(32'(rxCfg[i]), {7'h0, d[24:16], 2'h0, d[13:0]});
    end
    // transmit teardown on a random channel
    n = $random(seed) & 3;
    a = 32'h10 + 32'(4 * n);
    d = ($random(seed) & 32'h3FFF) | 32'h8000_0000;
    wrReg(a, d);
    rdChk(a, d);
    wrReg(a, d | 32'h4000_0000);
    for (int k = 0; k < 40 && txCfg[n].enable !== 1'b0; k++) @(posedge clk);
    rdChk(a, (d & 32'h3FFF) | 32'h4000_0000);
    // starvation in both handling modes, then on a disabled channel
    a = 32'h20 + 32'(4 * n);
    for (int e = 0; e < 3; e++) begin
      d = ($random(seed) & 32'h00FF_3FFF) | 32'h8000_0000 | (32'(e) << 24);
      wrReg(a, (e == 2) ? 32'h0 : d);
      rxStarve[n] <= 1'b1;
      seen = 2'h0;
      for (int k = 0; k < 4; k++) begin
        @(posedge clk);
        rxStarve[n] <= 1'b0;
        seen |= {rxDropPkt[n], rxRetryAlloc[n]};
      end
      chk(32'(seen), starveExp(e));
    end
    // receive teardown clears enable and leaves teardown set
    wrReg(a, 32'h8000_0000);
    rdChk(a, 32'h8000_0000);
    wrReg(a, 32'hC000_0000);
    for (int k = 0; k < 40 && rxCfg[n].enable !== 1'b0; k++) @(posedge clk);
    rdChk(a, 32'h4000_0000);
    // every suspend mode with random transaction lengths
    for (int m = 0; m < 4; m++) begin
      txnLen <= 4'(($random(seed) & 7) + 1);
      wrReg(32'h04, ($random(seed) & 32'hFFFF_FFFC) | 32'(m));
      rdChk(32'h04, 32'(m));
      emuSuspend <= 1'b1;
      for (int k = 0; k < 14; k++) begin
        @(posedge clk);
        chk(32'(engineHalted & engineBusy), 32'h0);
      end
      chk(32'({engineRun, engineHalted}), emuExp(m));
      emuSuspend <= 1'b0;
      repeat (3) @(posedge clk);
      chk(32'({engineRun, engineHalted}), 32'h2);
    end
    closeOut();
  end
endmodule
`default_nettype wire
